// ### csd_pkg.sv
package csd_pkg;

    // ------------------------------------------------------------
    // sources and domains
    // ------------------------------------------------------------
    localparam int CSD_NSRC = 5;
    localparam int CSD_NDOM = 5;

    localparam logic [2:0] CSD_SRC_SLOW_INTERNAL_OSC = 3'h0;
    localparam logic [2:0] CSD_SRC_FAST_INTERNAL_OSC = 3'h1;
    localparam logic [2:0] CSD_SRC_MAIN_OSC = 3'h2;
    localparam logic [2:0] CSD_SRC_SUB_OSC = 3'h3;
    localparam logic [2:0] CSD_SRC_PLL = 3'h4;

    localparam int CSD_DOM_SYS = 0;
    localparam int CSD_DOM_FLASH = 1;
    localparam int CSD_DOM_ETH = 2;
    localparam int CSD_DOM_EQUIP = 3;
    localparam int CSD_DOM_USB = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CSD_CORE_CLK_KHZ = 10000;
    localparam int CSD_SLOW_OSC_KHZ = 125;
    localparam int CSD_PROG_FETCH_NS = 10;
    localparam int CSD_PROG_FETCH_CYC_RAW =
        (CSD_PROG_FETCH_NS * CSD_CORE_CLK_KHZ + 999999) / 1000000;
    localparam int CSD_PROG_FETCH_CYC =
        (CSD_PROG_FETCH_CYC_RAW < 1) ? 1 : CSD_PROG_FETCH_CYC_RAW;
    localparam int CSD_ETH_MIN_KHZ = 12500;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] CSD_OFS_WRITE_PROTECT = 8'h00;
    localparam logic [7:0] CSD_OFS_CLOCK_SOURCE = 8'h04;
    localparam logic [7:0] CSD_OFS_SECONDARY = 8'h08;
    localparam logic [7:0] CSD_OFS_DIVIDE = 8'h0c;
    localparam logic [7:0] CSD_OFS_STATUS = 8'h10;

    localparam logic [7:0] CSD_WP_KEY = 8'ha5;
    localparam int CSD_WP_KEY_LSB = 8;
    localparam int CSD_WP_CLK_EN_BIT = 0;
    localparam int CSD_SRC_SEL_LSB = 0;
    localparam int CSD_EQ_SEL_LSB = 0;
    localparam int CSD_USB_THIRD_BIT = 4;
    localparam int CSD_DIV_SYS_LSB = 0;
    localparam int CSD_DIV_FLASH_LSB = 2;
    localparam int CSD_DIV_ETH_LSB = 4;
    localparam int CSD_STAT_BUSY_LSB = 0;
    localparam int CSD_STAT_SEL_LSB = 8;

    localparam logic CSD_RST_WP_EN = 1'b0;
    localparam logic [2:0] CSD_RST_SRC_SEL = CSD_SRC_SLOW_INTERNAL_OSC;
    localparam logic [2:0] CSD_RST_EQ_SEL = CSD_SRC_SLOW_INTERNAL_OSC;
    localparam logic CSD_RST_USB_THIRD = 1'b0;
    localparam logic [5:0] CSD_RST_DIV = 6'h00;

    localparam logic [1:0] CSD_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSD_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sel;
        logic [3:0] ratio;
    } csd_cfg_t;

    localparam csd_cfg_t CSD_RST_CFG = '{sel: CSD_RST_SRC_SEL,
                                         ratio: 4'h1};

    typedef enum logic [1:0] {
        CSD_RUN = 2'b01,
        CSD_GATED = 2'b10
    } csd_sw_t;

endpackage : csd_pkg

// ### csd_clock_select.sv
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - after reset every domain but usb (pll/4) runs from the 125 kHz slow internal osc
// - fast and slow internal oscillators join main, sub and watchdog osc
// - source select field picks one of five sources for the system, flash and ethernet domains
// - flash, ethernet and equipment bus domains are separate and tunable
// - flash domain times flash unit access only; fetch stays at 10 ns
// - ethernet controller and its dma share the ethernet clock domain
// - secondary control field selects the equipment bus base clock
// - secondary control field selects usb divisor of 1/3 or 1/4
// - clock register writes ignored unless protect register unlocked
module csd_clock_select
    import csd_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [CSD_NSRC-1:0] src_clk_in,
    input wire logic watchdog_osc_in,
    output logic core_system_clock,
    output logic flash_ctrl_clock,
    output logic ethernet_periph_clock,
    output logic equipment_bus_clock,
    output logic usb_clock,
    output logic independent_watchdog_clock,
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);

    generate
        if (ADDR_W < 5) begin : g_chk
            $error("ADDR_W too small for register map");
        end
    endgenerate

    // ------------------------------------------------------------
    // register write side
    // ------------------------------------------------------------
    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic wp_en_reg, wp_en_next;
    logic [2:0] src_sel_reg, src_sel_next;
    logic [2:0] eq_sel_reg, eq_sel_next;
    logic usb_third_reg, usb_third_next;
    logic [5:0] div_reg, div_next;
    logic [7:0] woff;

    assign woff = 8'(awaddr_reg);

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        wp_en_next = wp_en_reg;
        src_sel_next = src_sel_reg;
        eq_sel_next = eq_sel_reg;
        usb_third_next = usb_third_reg;
        div_next = div_reg;
        if (s_awvalid && awready_reg) begin
            aw_have_next = 1'b1;
            awaddr_next = s_awaddr;
        end
        if (s_wvalid && wready_reg) begin
            w_have_next = 1'b1;
            wdata_next = s_wdata;
            wstrb_next = s_wstrb;
        end
        if (bvalid_reg && s_bready) begin
            bvalid_next = 1'b0;
        end
        if (aw_have_reg && w_have_reg && !bvalid_reg) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = CSD_RESP_OKAY;
            case (woff)
                CSD_OFS_WRITE_PROTECT: begin
                    // key and enable must land in one write
                    if (wstrb_reg[1:0] == 2'b11 &&
                        wdata_reg[CSD_WP_KEY_LSB +: 8] == CSD_WP_KEY) begin
                        wp_en_next = wdata_reg[CSD_WP_CLK_EN_BIT];
                    end
                end
                CSD_OFS_CLOCK_SOURCE: begin
                    // codes above the pll are refused, keeping the mux legal
                    if (wp_en_reg && wstrb_reg[0] &&
                        wdata_reg[CSD_SRC_SEL_LSB +: 3] <= CSD_SRC_PLL) begin
                        src_sel_next = wdata_reg[CSD_SRC_SEL_LSB +: 3];
                    end
                end
                CSD_OFS_SECONDARY: begin
                    if (wp_en_reg && wstrb_reg[0]) begin
                        if (wdata_reg[CSD_EQ_SEL_LSB +: 3] <= CSD_SRC_PLL) begin
                            eq_sel_next = wdata_reg[CSD_EQ_SEL_LSB +: 3];
                        end
                        usb_third_next = wdata_reg[CSD_USB_THIRD_BIT];
                    end
                end
                CSD_OFS_DIVIDE: begin
                    if (wp_en_reg && wstrb_reg[0]) begin
                        div_next = wdata_reg[5:0];
                    end
                end
                CSD_OFS_STATUS: begin
                end
                default: begin
                    bresp_next = CSD_RESP_SLVERR;
                end
            endcase
        end
        awready_next = !aw_have_next && !bvalid_next;
        wready_next = !w_have_next && !bvalid_next;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= CSD_RESP_OKAY;
            wp_en_reg <= CSD_RST_WP_EN;
            src_sel_reg <= CSD_RST_SRC_SEL;
            eq_sel_reg <= CSD_RST_EQ_SEL;
            usb_third_reg <= CSD_RST_USB_THIRD;
            div_reg <= CSD_RST_DIV;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            wp_en_reg <= wp_en_next;
            src_sel_reg <= src_sel_next;
            eq_sel_reg <= eq_sel_next;
            usb_third_reg <= usb_third_next;
            div_reg <= div_next;
        end
    end

    // ------------------------------------------------------------
    // register read side
    // ------------------------------------------------------------
    logic arready_reg, arready_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [CSD_NDOM-1:0] dom_busy;
    csd_cfg_t act_sys;
    logic [7:0] roff;

    assign roff = 8'(s_araddr);

    always_comb begin
        arready_next = arready_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = CSD_RESP_OKAY;
            rdata_next = 32'h0;
            case (roff)
                CSD_OFS_WRITE_PROTECT:
                    rdata_next[CSD_WP_CLK_EN_BIT] = wp_en_reg;
                CSD_OFS_CLOCK_SOURCE:
                    rdata_next[CSD_SRC_SEL_LSB +: 3] = src_sel_reg;
                CSD_OFS_SECONDARY: begin
                    rdata_next[CSD_EQ_SEL_LSB +: 3] = eq_sel_reg;
                    rdata_next[CSD_USB_THIRD_BIT] = usb_third_reg;
                end
                CSD_OFS_DIVIDE:
                    rdata_next[5:0] = div_reg;
                CSD_OFS_STATUS: begin
                    rdata_next[CSD_STAT_BUSY_LSB +: CSD_NDOM] = dom_busy;
                    rdata_next[CSD_STAT_SEL_LSB +: 3] = act_sys.sel;
                end
                default:
                    rresp_next = CSD_RESP_SLVERR;
            endcase
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0;
            rresp_reg <= CSD_RESP_OKAY;
        end else begin
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // ------------------------------------------------------------
    // domain targets
    // ------------------------------------------------------------
    csd_cfg_t tgt [CSD_NDOM];

    always_comb begin
        // system, flash and ethernet share one source select
        tgt[CSD_DOM_SYS].sel = src_sel_reg;
        tgt[CSD_DOM_SYS].ratio = 4'h1 << div_reg[CSD_DIV_SYS_LSB +: 2];
        tgt[CSD_DOM_FLASH].sel = src_sel_reg;
        tgt[CSD_DOM_FLASH].ratio = 4'h1 << div_reg[CSD_DIV_FLASH_LSB +: 2];
        tgt[CSD_DOM_ETH].sel = src_sel_reg;
        tgt[CSD_DOM_ETH].ratio = 4'h1 << div_reg[CSD_DIV_ETH_LSB +: 2];
        tgt[CSD_DOM_EQUIP].sel = eq_sel_reg;
        tgt[CSD_DOM_EQUIP].ratio = 4'h1;
        tgt[CSD_DOM_USB].sel = CSD_SRC_PLL;
        tgt[CSD_DOM_USB].ratio = usb_third_reg ? 4'h3 : 4'h4;
    end

    // ------------------------------------------------------------
    // glitch-free switch and divider per domain
    // ------------------------------------------------------------
    // src_clk_in: slow int, fast int, main, sub, pll
    logic [CSD_NSRC-1:0] src_prev_reg;
    logic [CSD_NSRC-1:0] src_rise;
    logic [CSD_NDOM-1:0] dom_clk;
    logic wdt_clk_reg;

    assign src_rise = src_clk_in & ~src_prev_reg;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            src_prev_reg <= '0;
            wdt_clk_reg <= 1'b0;
        end else begin
            src_prev_reg <= src_clk_in;
            wdt_clk_reg <= watchdog_osc_in;
        end
    end

    genvar d;
    generate
        for (d = 0; d < CSD_NDOM; d++) begin : g_dom
            csd_sw_t st_reg, st_next;
            csd_cfg_t act_reg, act_next;
            logic [2:0] cnt_reg, cnt_next;
            logic clk_reg, clk_next;
            // switching only while the output is low and then waiting for
            // the new source to be low trades a stretched low phase for
            // never cutting a high pulse short
            always_comb begin
                st_next = st_reg;
                act_next = act_reg;
                cnt_next = cnt_reg;
                clk_next = clk_reg;
                case (st_reg)
                    CSD_RUN: begin
                        if (act_reg.ratio == 4'h1) begin
                            clk_next = src_clk_in[act_reg.sel];
                        end else if (src_rise[act_reg.sel]) begin
                            if ({1'b0, cnt_reg} == act_reg.ratio - 4'h1) begin
                                cnt_next = 3'h0;
                            end else begin
                                cnt_next = cnt_reg + 3'h1;
                            end
                            clk_next = ({1'b0, cnt_next} < (act_reg.ratio >> 1));
                        end
                        if (act_reg != tgt[d] && !clk_next) begin
                            st_next = CSD_GATED;
                        end
                    end
                    CSD_GATED: begin
                        clk_next = 1'b0;
                        if (!src_clk_in[tgt[d].sel]) begin
                            act_next = tgt[d];
                            cnt_next = 3'(tgt[d].ratio - 4'h1);
                            st_next = CSD_RUN;
                        end
                    end
                    default: begin
                        st_next = CSD_GATED;
                        clk_next = 1'b0;
                    end
                endcase
            end

            always_ff @(posedge core_clk) begin
                if (srst) begin
                    st_reg <= CSD_RUN;
                    act_reg <= CSD_RST_CFG;
                    cnt_reg <= 3'h0;
                    clk_reg <= 1'b0;
                end else begin
                    st_reg <= st_next;
                    act_reg <= act_next;
                    cnt_reg <= cnt_next;
                    clk_reg <= clk_next;
                end
            end

            assign dom_clk[d] = clk_reg;
            assign dom_busy[d] = (st_reg == CSD_GATED);
        end
    endgenerate

    assign act_sys = g_dom[CSD_DOM_SYS].act_reg;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign core_system_clock = dom_clk[CSD_DOM_SYS];
    // program fetch timing rides on the core clock, not on this domain
    assign flash_ctrl_clock = dom_clk[CSD_DOM_FLASH];
    // one net feeds both the controller and its dma engine
    assign ethernet_periph_clock = dom_clk[CSD_DOM_ETH];
    assign equipment_bus_clock = dom_clk[CSD_DOM_EQUIP];
    assign usb_clock = dom_clk[CSD_DOM_USB];
    assign independent_watchdog_clock = wdt_clk_reg;
    assign s_awready = awready_reg;
    assign s_wready = wready_reg;
    assign s_bvalid = bvalid_reg;
    assign s_bresp = bresp_reg;
    assign s_arready = arready_reg;
    assign s_rvalid = rvalid_reg;
    assign s_rdata = rdata_reg;
    assign s_rresp = rresp_reg;

endmodule : csd_clock_select

// ### csd_clock_select_props.sv
`timescale 1ns/1ps
module csd_clock_select_props
    import csd_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [CSD_NSRC-1:0] src_clk_in,
    input wire logic watchdog_osc_in,
    input wire logic core_system_clock,
    input wire logic flash_ctrl_clock,
    input wire logic ethernet_periph_clock,
    input wire logic equipment_bus_clock,
    input wire logic usb_clock,
    input wire logic independent_watchdog_clock,
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready
);
    // ------------------------------------------------------------
    // helper: any write seen since reset ends the default phase
    // ------------------------------------------------------------
    logic touched_reg;
    logic touched_next;
    always_comb begin
        touched_next = touched_reg | (s_awvalid & s_awready);
    end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            touched_reg <= 1'b0;
        end else begin
            touched_reg <= touched_next;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_wr_take;
        s_awvalid && s_awready && s_wvalid && s_wready;
    endsequence
    sequence s_wr_done;
        s_bvalid && s_bready;
    endsequence
    property p_rst_quiet;
        $fell(srst) |-> !core_system_clock && !flash_ctrl_clock
            && !ethernet_periph_clock && !usb_clock && !s_bvalid;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("domain clock or response not low after reset");
    property p_follow;
        !touched_reg && !$past(srst) |->
            core_system_clock == $past(src_clk_in[0])
            && flash_ctrl_clock == $past(src_clk_in[0])
            && ethernet_periph_clock == $past(src_clk_in[0])
            && equipment_bus_clock == $past(src_clk_in[0]);
    endproperty
    a_follow: assert property (p_follow)
        else $error("default domains do not follow slow osc");
    property p_wdog;
        !$past(srst) |->
            independent_watchdog_clock == $past(watchdog_osc_in);
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog clock not passed through");
    property p_bvalid;
        s_wr_take |-> !s_bvalid ##2 s_bvalid;
    endproperty
    a_bvalid: assert property (p_bvalid)
        else $error("write response late");
    property p_bblock;
        s_bvalid |-> !s_awready && !s_wready;
    endproperty
    a_bblock: assert property (p_bblock)
        else $error("write accepted while response pending");
    property p_bdone;
        s_wr_done |=> !s_bvalid ##1 (s_awready && s_wready);
    endproperty
    a_bdone: assert property (p_bdone)
        else $error("write channel not reopened");
    property p_rvalid;
        s_arvalid && s_arready |=> s_rvalid && !s_arready;
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read answer late");
    property p_rdone;
        s_rvalid && s_rready |=> !s_rvalid && s_arready;
    endproperty
    a_rdone: assert property (p_rdone)
        else $error("read channel not reopened");
    property p_sys_whole;
        $rose(core_system_clock) |=> core_system_clock;
    endproperty
    a_sys_whole: assert property (p_sys_whole)
        else $error("system clock high phase cut");
    property p_usb_whole;
        $rose(usb_clock) |=> usb_clock;
    endproperty
    a_usb_whole: assert property (p_usb_whole)
        else $error("usb clock high phase cut");
endmodule : csd_clock_select_props

// ### csd_osc_model.sv
`timescale 1ns/1ps
module csd_osc_model
    import csd_pkg::*;
(
    input wire logic core_clk,
    output logic [CSD_NSRC-1:0] src_clk_out,
    output logic watchdog_osc_out
);
    // ------------------------------------------------------------
    // free running sources; half periods in core cycles
    // ------------------------------------------------------------
    localparam int HALF [CSD_NSRC+1] = '{8, 2, 3, 5, 1, 6};
    int cnt [CSD_NSRC+1];
    logic [CSD_NSRC:0] lvl = '0;
    initial begin
        foreach (cnt[i]) cnt[i] = 0;
    end
    always @(posedge core_clk) begin
        foreach (cnt[i]) begin
            if (cnt[i] + 1 >= HALF[i]) begin
                cnt[i] <= 0;
                lvl[i] <= ~lvl[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end
    assign src_clk_out = lvl[CSD_NSRC-1:0];
    assign watchdog_osc_out = lvl[CSD_NSRC];
endmodule : csd_osc_model

// ### csd_clock_select_tb_top.sv
`timescale 1ns/1ps
module csd_clock_select_tb_top;
    import csd_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [CSD_NSRC-1:0] src_clk_in;
    logic watchdog_osc_in;
    logic core_system_clock, flash_ctrl_clock, ethernet_periph_clock;
    logic equipment_bus_clock, usb_clock, independent_watchdog_clock;
    logic [7:0] s_awaddr = '0, s_araddr = '0;
    logic [31:0] s_wdata = '0, s_rdata;
    logic [3:0] s_wstrb = '0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0;
    logic s_arvalid = 0, s_rready = 0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    int err_count = 0, cmp_count = 0, cyc = 0;
    localparam int PER [CSD_NSRC] = '{16, 4, 6, 10, 2};
    wire logic [CSD_NDOM-1:0] dclk = {usb_clock, equipment_bus_clock,
        ethernet_periph_clock, flash_ctrl_clock, core_system_clock};
    csd_clock_select u_dut (.*);
    csd_osc_model u_osc (.core_clk(core_clk), .src_clk_out(src_clk_in),
        .watchdog_osc_out(watchdog_osc_in));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // the limit sits far above the few thousand cycles the run needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] st, input logic [1:0] er);
        logic aw, w, ra, rw, bv;
        logic [1:0] r;
        @(posedge core_clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= st;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        aw = 1;
        w = 1;
        while (aw || w) begin
            @(negedge core_clk);
            ra = s_awready;
            rw = s_wready;
            @(posedge core_clk);
            if (ra && aw) begin
                s_awvalid <= 1'b0;
                aw = 0;
            end
            if (rw && w) begin
                s_wvalid <= 1'b0;
                w = 0;
            end
        end
        do begin
            @(negedge core_clk);
            bv = s_bvalid;
            r = s_bresp;
            @(posedge core_clk);
        end while (bv !== 1'b1);
        s_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic t;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge core_clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(negedge core_clk);
            t = s_arready;
            @(posedge core_clk);
        end while (t !== 1'b1);
        s_arvalid <= 1'b0;
        do begin
            @(negedge core_clk);
            t = s_rvalid;
            d = s_rdata;
            r = s_rresp;
            @(posedge core_clk);
        end while (t !== 1'b1);
        s_rready <= 1'b0;
        chk("rdata", ed, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask : rd
    task automatic next_rise(input int i, output int n);
        logic p;
        n = 0;
        do begin
            p = dclk[i];
            @(posedge core_clk);
            #1;
            n++;
        end while (p !== 1'b0 || dclk[i] !== 1'b1);
    endtask : next_rise
    // settle first: a switch waits for low phases of old and new source
    task automatic measure(input int i, input int per);
        int n;
        repeat (80) @(posedge core_clk);
        #1;
        next_rise(i, n);
        next_rise(i, n);
        chk("period", per, n);
    endtask : measure
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        rd(CSD_OFS_WRITE_PROTECT, 0, CSD_RESP_OKAY);
        rd(CSD_OFS_CLOCK_SOURCE, 0, CSD_RESP_OKAY);
        rd(CSD_OFS_SECONDARY, 0, CSD_RESP_OKAY);
        rd(CSD_OFS_DIVIDE, 0, CSD_RESP_OKAY);
        rd(CSD_OFS_STATUS, 0, CSD_RESP_OKAY);
        for (int i = 0; i < 4; i++) measure(i, PER[0]);
        measure(CSD_DOM_USB, 4 * PER[4]);
        wr(CSD_OFS_CLOCK_SOURCE, 1, 4'hf, CSD_RESP_OKAY);
        rd(CSD_OFS_CLOCK_SOURCE, 0, CSD_RESP_OKAY);
        wr(CSD_OFS_WRITE_PROTECT, 32'h5a01, 4'h3, CSD_RESP_OKAY);
        rd(CSD_OFS_WRITE_PROTECT, 0, CSD_RESP_OKAY);
        wr(CSD_OFS_WRITE_PROTECT, 32'ha501, 4'h3, CSD_RESP_OKAY);
        rd(CSD_OFS_WRITE_PROTECT, 1, CSD_RESP_OKAY);
        wr(CSD_OFS_DIVIDE, 32'h09, 4'h1, CSD_RESP_OKAY);
        for (int s = 0; s < CSD_NSRC; s++) begin
            wr(CSD_OFS_CLOCK_SOURCE, s, 4'h1, CSD_RESP_OKAY);
            measure(CSD_DOM_SYS, 2 * PER[s]);
            measure(CSD_DOM_FLASH, 4 * PER[s]);
            measure(CSD_DOM_ETH, PER[s]);
            rd(CSD_OFS_STATUS, s << 8, CSD_RESP_OKAY);
        end
        wr(CSD_OFS_CLOCK_SOURCE, 5, 4'h1, CSD_RESP_OKAY);
        rd(CSD_OFS_CLOCK_SOURCE, 4, CSD_RESP_OKAY);
        for (int s = 0; s < CSD_NSRC; s++) begin
            wr(CSD_OFS_SECONDARY, s, 4'h1, CSD_RESP_OKAY);
            measure(CSD_DOM_EQUIP, PER[s]);
        end
        wr(CSD_OFS_SECONDARY, 32'h10, 4'h1, CSD_RESP_OKAY);
        rd(CSD_OFS_SECONDARY, 32'h10, CSD_RESP_OKAY);
        measure(CSD_DOM_USB, 3 * PER[4]);
        wr(CSD_OFS_SECONDARY, 0, 4'h1, CSD_RESP_OKAY);
        measure(CSD_DOM_USB, 4 * PER[4]);
        wr(CSD_OFS_DIVIDE, 32'h11, 4'h1, CSD_RESP_OKAY);
        measure(CSD_DOM_ETH, 2 * PER[4]);
        measure(CSD_DOM_SYS, 2 * PER[4]);
        wr(8'h14, 1, 4'hf, CSD_RESP_SLVERR);
        rd(8'h14, 0, CSD_RESP_SLVERR);
        wr(CSD_OFS_STATUS, 32'hffffffff, 4'hf, CSD_RESP_OKAY);
        rd(CSD_OFS_STATUS, 32'h400, CSD_RESP_OKAY);
        wr(CSD_OFS_WRITE_PROTECT, 32'ha500, 4'h3, CSD_RESP_OKAY);
        wr(CSD_OFS_CLOCK_SOURCE, 0, 4'h1, CSD_RESP_OKAY);
        rd(CSD_OFS_CLOCK_SOURCE, 4, CSD_RESP_OKAY);
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        rd(CSD_OFS_CLOCK_SOURCE, 0, CSD_RESP_OKAY);
        measure(CSD_DOM_SYS, PER[0]);
        wrap_up();
    end
endmodule : csd_clock_select_tb_top
bind csd_clock_select csd_clock_select_props u_props (.*);
